// *** rtl/pxo_port0_out.sv ***
// port 0 output pin mux: strap role, data and valid mapping, isolate
//
// Functional notes
// (R1) codes 000 MAC, 001 PHY, 010/011 PHY at 200 Mbps.
// (R2) codes 100/101 RMII clock out, 110 RMII clock in, 111 reserved.
// (R3) MAC role: nibble pins carry transmit data toward the PHY.
// (R4) MAC role: valid pin is transmit enable for the nibble.
// (R5) PHY role: nibble pins carry receive data toward the MAC.
// (R6) PHY role: valid pin is receive data valid.
// (R7) RMII role: data bit 2 and upper bits unused, not driven.
// (R8) RMII role: data bits 1 and 0 carry the receive dibit.
// (R9) RMII role: valid pin is carrier sense with data valid.
// (R10) PHY and RMII roles: isolate turns off data and valid drivers.
// (R11) MAC role: output pins timed to the PHY-supplied reference clock.
// (R12) RMII role: one 50 MHz reference clock times all data pins.
// (R13) strap levels latched during reset, role held until next reset.
// (R14) reserved code keeps every output driver disabled.
`timescale 1ns/100ps

module pxo_port0_out
(
  // system clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       rst_in,
  // link reference clock, input in every role
  input  wire logic                       port0_out_ref_clock_in,
  // straps and control, asynchronous levels
  input  wire logic [pxo_pkg::PXO_CODE_W-1:0] port0_role_strap_code_in,
  input  wire logic                       vphy_isolate_bit_in,
  // switch side stream, on the link clock
  input  wire logic [pxo_pkg::PXO_NIB_W-1:0]  sw_out_nibble_in,
  input  wire logic                       sw_out_valid_in,
  // pins, link clock domain
  output logic [pxo_pkg::PXO_NIB_W-1:0]   port0_out_data_nibble_out,
  output logic [pxo_pkg::PXO_NIB_W-1:0]   port0_out_data_oe_out,
  output logic                            port0_out_valid_out,
  output logic                            port0_out_valid_oe_out,
  // status, system clock domain
  output logic [pxo_pkg::PXO_CODE_W-1:0]  port0_role_code_out,
  output logic                            port0_role_reserved_out,
  output logic                            port0_ref_clock_drive_out
);
  import pxo_pkg::*;

  // ---------------------------------------------------------------
  // system clock state
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [2:0] role_code;
    logic       role_valid;
    logic       reserved;
    logic       clk_drive;
  } pxo_sys_t;

  pxo_sys_t sys_r;
  pxo_sys_t sys_nxt;

  always_comb
  begin
    sys_nxt          = sys_r;
    sys_nxt.strap_s1 = port0_role_strap_code_in;
    sys_nxt.strap_s2 = sys_r.strap_s1;
    if (rst_in)
    begin
      // keep sampling while reset holds; last value wins
      sys_nxt.role_code  = sys_r.strap_s2;  // see (R13)
      sys_nxt.role_valid = 1'b0;
      sys_nxt.reserved   = 1'b0;
      sys_nxt.clk_drive  = 1'b0;
    end
    else
    begin
      sys_nxt.role_valid = 1'b1;
      // see (R1) (R2)
      sys_nxt.reserved   = pxo_decode(sys_r.role_code) == PXO_ROLE_RESERVED;
      sys_nxt.clk_drive  = pxo_clk_driven(sys_r.role_code);
    end
  end

  always_ff @(posedge mclk_in)
  begin
    sys_r <= sys_nxt;
  end

  assign port0_role_code_out       = sys_r.role_code;
  assign port0_role_reserved_out   = sys_r.reserved;
  assign port0_ref_clock_drive_out = sys_r.clk_drive;

  // ---------------------------------------------------------------
  // link clock reset crossing
  // ---------------------------------------------------------------
  // the link clock may stop, so the link side keeps its own reset copy
  logic lrst_s1_r;
  logic lrst_s2_r;

  always_ff @(posedge port0_out_ref_clock_in)
  begin
    lrst_s1_r <= rst_in;
    lrst_s2_r <= lrst_s1_r;
  end

  // ---------------------------------------------------------------
  // link clock state
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic [2:0] role_s1;
    logic [2:0] role_s2;
    logic       vld_s1;
    logic       vld_s2;
    logic       iso_s1;
    logic       iso_s2;
    logic [3:0] data;
    logic [3:0] data_oe;
    logic       valid;
    logic       valid_oe;
  } pxo_link_t;

  pxo_link_t lnk_r;
  pxo_link_t lnk_nxt;
  pxo_role_t lrole;

  // role code is static after reset, so a plain two-flop bus is safe
  assign lrole = lnk_r.vld_s2 ? pxo_decode(lnk_r.role_s2) : PXO_ROLE_RESERVED;

  always_comb
  begin
    lnk_nxt        = lnk_r;
    lnk_nxt.role_s1 = sys_r.role_code;
    lnk_nxt.role_s2 = lnk_r.role_s1;
    lnk_nxt.vld_s1  = sys_r.role_valid;
    lnk_nxt.vld_s2  = lnk_r.vld_s1;
    lnk_nxt.iso_s1  = vphy_isolate_bit_in;
    lnk_nxt.iso_s2  = lnk_r.iso_s1;
    lnk_nxt.data    = sw_out_nibble_in;
    lnk_nxt.valid   = sw_out_valid_in;
    case (lrole)
      PXO_ROLE_MII_MAC:
      begin
        // transmit side toward a PHY; isolate has no say here
        lnk_nxt.data_oe  = PXO_OE_ALL;  // see (R3) (R11)
        lnk_nxt.valid_oe = 1'b1;        // see (R4)
      end
      PXO_ROLE_MII_PHY, PXO_ROLE_FAST_PHY:
      begin
        // see (R5) (R6) (R10)
        lnk_nxt.data_oe  = lnk_r.iso_s2 ? PXO_OE_NONE : PXO_OE_ALL;
        lnk_nxt.valid_oe = !lnk_r.iso_s2;
      end
      PXO_ROLE_RMII_PHY:
      begin
        lnk_nxt.data[3:2] = 2'h0;         // see (R7)
        // see (R8) (R9) (R10) (R12)
        lnk_nxt.data_oe  = lnk_r.iso_s2 ? PXO_OE_NONE : PXO_OE_RMII;
        lnk_nxt.valid_oe = !lnk_r.iso_s2;
      end
      default:
      begin
        lnk_nxt.data     = PXO_DATA_RST;  // see (R14)
        lnk_nxt.valid    = 1'b0;
        lnk_nxt.data_oe  = PXO_OE_NONE;
        lnk_nxt.valid_oe = 1'b0;
      end
    endcase
    if (lrst_s2_r)
    begin
      lnk_nxt          = '0;
      lnk_nxt.role_s1  = PXO_CODE_RST;
      lnk_nxt.iso_s1   = vphy_isolate_bit_in;
    end
  end

  always_ff @(posedge port0_out_ref_clock_in)
  begin
    lnk_r <= lnk_nxt;
  end

  assign port0_out_data_nibble_out = lnk_r.data;
  assign port0_out_data_oe_out     = lnk_r.data_oe;
  assign port0_out_valid_out       = lnk_r.valid;
  assign port0_out_valid_oe_out    = lnk_r.valid_oe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_strap_held: assert property ( // see (R13)
    @(posedge mclk_in) disable iff (rst_in)
    !$past(rst_in) |-> $stable(port0_role_code_out))
    else $error("role code changed outside reset");

  a_code_decode: assert property ( // see (R2)
    @(posedge mclk_in) disable iff (rst_in)
    !$past(rst_in) |->
      port0_role_reserved_out == ($past(sys_r.role_code) == 3'h7))
    else $error("reserved flag does not match latched code");

  a_mac_data: assert property ( // see (R3)
    @(posedge port0_out_ref_clock_in) disable iff (lrst_s2_r)
    lrole == PXO_ROLE_MII_MAC |=>
      port0_out_data_nibble_out == $past(sw_out_nibble_in)
      && port0_out_data_oe_out == 4'hf)
    else $error("mac role nibble not driven with transmit data");

  a_mac_valid: assert property ( // see (R4)
    @(posedge port0_out_ref_clock_in) disable iff (lrst_s2_r)
    lrole == PXO_ROLE_MII_MAC |=>
      port0_out_valid_out == $past(sw_out_valid_in)
      && port0_out_valid_oe_out)
    else $error("mac role transmit enable wrong");

  a_phy_data: assert property ( // see (R5)
    @(posedge port0_out_ref_clock_in) disable iff (lrst_s2_r)
    (lrole == PXO_ROLE_MII_PHY || lrole == PXO_ROLE_FAST_PHY)
      && !lnk_r.iso_s2 |=>
      port0_out_data_nibble_out == $past(sw_out_nibble_in)
      && port0_out_data_oe_out == 4'hf)
    else $error("phy role nibble not driven with receive data");

  a_phy_valid: assert property ( // see (R6)
    @(posedge port0_out_ref_clock_in) disable iff (lrst_s2_r)
    lrole == PXO_ROLE_MII_PHY && !lnk_r.iso_s2 |=>
      port0_out_valid_out == $past(sw_out_valid_in)
      && port0_out_valid_oe_out)
    else $error("phy role receive valid wrong");

  a_rmii_upper: assert property ( // see (R7)
    @(posedge port0_out_ref_clock_in) disable iff (lrst_s2_r)
    lrole == PXO_ROLE_RMII_PHY |=>
      port0_out_data_oe_out[3:2] == 2'h0
      && port0_out_data_nibble_out[3:2] == 2'h0)
    else $error("rmii role drives unused data bits");

  a_rmii_dibit: assert property ( // see (R8)
    @(posedge port0_out_ref_clock_in) disable iff (lrst_s2_r)
    lrole == PXO_ROLE_RMII_PHY && !lnk_r.iso_s2 |=>
      port0_out_data_nibble_out[1:0] == $past(sw_out_nibble_in[1:0])
      && port0_out_data_oe_out[1:0] == 2'h3)
    else $error("rmii role dibit not driven");

  a_rmii_valid: assert property ( // see (R9)
    @(posedge port0_out_ref_clock_in) disable iff (lrst_s2_r)
    lrole == PXO_ROLE_RMII_PHY && !lnk_r.iso_s2 |=>
      port0_out_valid_out == $past(sw_out_valid_in)
      && port0_out_valid_oe_out)
    else $error("rmii role carrier and valid wrong");

  a_iso_off: assert property ( // see (R10)
    @(posedge port0_out_ref_clock_in) disable iff (lrst_s2_r)
    lrole != PXO_ROLE_MII_MAC && vphy_isolate_bit_in [*3] |=>
      port0_out_data_oe_out == 4'h0 && !port0_out_valid_oe_out)
    else $error("isolate did not release the drivers in three clocks");

  a_rsv_off: assert property ( // see (R14)
    @(posedge port0_out_ref_clock_in) disable iff (lrst_s2_r)
    lrole == PXO_ROLE_RESERVED |=>
      port0_out_data_oe_out == 4'h0 && !port0_out_valid_oe_out
      && !port0_out_valid_out)
    else $error("reserved code left a driver on");

  a_fast_valid: assert property ( // see (R6)
    @(posedge port0_out_ref_clock_in) disable iff (lrst_s2_r)
    lrole == PXO_ROLE_FAST_PHY && !lnk_r.iso_s2 |=>
      port0_out_valid_out == $past(sw_out_valid_in)
      && port0_out_valid_oe_out)
    else $error("fast phy role receive valid wrong");

  // the mac role has no isolate; the attached phy owns the line
  a_mac_drive: assert property ( // see (R3) (R4)
    @(posedge port0_out_ref_clock_in) disable iff (lrst_s2_r)
    lrole == PXO_ROLE_MII_MAC && lnk_r.iso_s2 |=>
      port0_out_data_oe_out == 4'hf && port0_out_valid_oe_out)
    else $error("mac role drivers dropped by isolate");

  a_iso_release: assert property ( // see (R10)
    @(posedge port0_out_ref_clock_in) disable iff (lrst_s2_r)
    ((lrole == PXO_ROLE_MII_PHY || lrole == PXO_ROLE_FAST_PHY
      || lrole == PXO_ROLE_RMII_PHY) && !vphy_isolate_bit_in) [*3] |=>
      port0_out_data_oe_out != 4'h0 && port0_out_valid_oe_out)
    else $error("drivers stayed off after isolate cleared");

  // reset copy on the link side must silence the pins within one edge
  a_link_quiet: assert property ( // see (R14)
    @(posedge port0_out_ref_clock_in)
    lrst_s2_r |=>
      port0_out_data_oe_out == 4'h0 && !port0_out_valid_oe_out)
    else $error("link reset left a driver on");

  a_clk_drive: assert property ( // see (R1) (R2)
    @(posedge mclk_in) disable iff (rst_in)
    !$past(rst_in) |->
      port0_ref_clock_drive_out
        == ($past(sys_r.role_code) != PXO_CODE_MII_MAC
            && $past(sys_r.role_code) < PXO_CODE_RMII_CKIN))
    else $error("clock drive status does not match latched code");

  a_rst_status: assert property ( // see (R13)
    @(posedge mclk_in)
    rst_in |=> !port0_role_reserved_out && !port0_ref_clock_drive_out)
    else $error("status flags not cleared by reset");

endmodule

// *** include/pxo_pkg.sv ***
// package: port 0 output role codes, masks and decode functions
package pxo_pkg;

  // ---------------------------------------------------------------
  // strap codes
  // ---------------------------------------------------------------
  localparam logic [2:0] PXO_CODE_MII_MAC   = 3'h0;
  localparam logic [2:0] PXO_CODE_MII_PHY   = 3'h1;
  localparam logic [2:0] PXO_CODE_FAST_12MA = 3'h2;
  localparam logic [2:0] PXO_CODE_FAST_16MA = 3'h3;
  localparam logic [2:0] PXO_CODE_RMII_12MA = 3'h4;
  localparam logic [2:0] PXO_CODE_RMII_16MA = 3'h5;
  localparam logic [2:0] PXO_CODE_RMII_CKIN = 3'h6;
  localparam logic [2:0] PXO_CODE_RESERVED  = 3'h7;

  // ---------------------------------------------------------------
  // widths, enables and reset values
  // ---------------------------------------------------------------
  localparam int         PXO_NIB_W     = 4;
  localparam int         PXO_CODE_W    = 3;
  localparam logic [3:0] PXO_OE_ALL    = 4'hf;
  localparam logic [3:0] PXO_OE_NONE   = 4'h0;
  localparam logic [3:0] PXO_OE_RMII   = 4'h3;
  localparam logic [3:0] PXO_DATA_RST  = 4'h0;
  localparam logic [2:0] PXO_CODE_RST  = 3'h0;

  // ---------------------------------------------------------------
  // roles
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    PXO_ROLE_MII_MAC,
    PXO_ROLE_MII_PHY,
    PXO_ROLE_FAST_PHY,
    PXO_ROLE_RMII_PHY,
    PXO_ROLE_RESERVED
  } pxo_role_t;

  function automatic pxo_role_t pxo_decode(input logic [2:0] code);
    pxo_role_t r;
    r = PXO_ROLE_RESERVED;
    case (code)
      PXO_CODE_MII_MAC:   r = PXO_ROLE_MII_MAC;
      PXO_CODE_MII_PHY:   r = PXO_ROLE_MII_PHY;
      PXO_CODE_FAST_12MA: r = PXO_ROLE_FAST_PHY;
      PXO_CODE_FAST_16MA: r = PXO_ROLE_FAST_PHY;
      PXO_CODE_RMII_12MA: r = PXO_ROLE_RMII_PHY;
      PXO_CODE_RMII_16MA: r = PXO_ROLE_RMII_PHY;
      PXO_CODE_RMII_CKIN: r = PXO_ROLE_RMII_PHY;
      default:            r = PXO_ROLE_RESERVED;
    endcase
    return r;
  endfunction

  // true where the device sources the output reference clock
  function automatic logic pxo_clk_driven(input logic [2:0] code);
    logic d;
    d = 1'b0;
    case (code)
      PXO_CODE_MII_PHY:   d = 1'b1;
      PXO_CODE_FAST_12MA: d = 1'b1;
      PXO_CODE_FAST_16MA: d = 1'b1;
      PXO_CODE_RMII_12MA: d = 1'b1;
      PXO_CODE_RMII_16MA: d = 1'b1;
      default:            d = 1'b0;
    endcase
    return d;
  endfunction

endpackage

// *** sim/pxo_far_end.sv ***
// far-end model: external mac or phy watching the port 0 output pins
`timescale 1ns/100ps
module pxo_far_end
(
  // link reference clock
  input  wire logic       ref_clock_in,
  // pins from the device
  input  wire logic [3:0] data_in,
  input  wire logic [3:0] data_oe_in,
  input  wire logic       valid_in,
  input  wire logic       valid_oe_in,
  // resolved wire levels
  output logic      [3:0] wire_data_out,
  output logic            wire_valid_out
);
  logic [3:0] last_r   = 4'h0;
  logic       last_v_r = 1'b0;
  // undriven wire shows inverse of last level, never a stale match
  always_comb
  begin
    wire_data_out  = (data_in & data_oe_in) | (~last_r & ~data_oe_in);
    wire_valid_out = valid_oe_in ? valid_in : ~last_v_r;
  end
  // one shared reference clock times data and valid
  always_ff @(posedge ref_clock_in)
  begin
    last_r   <= wire_data_out;
    last_v_r <= wire_valid_out;
  end
endmodule

// *** sim/pxo_port0_out_test.sv ***
// self-checking bench for the port 0 output pin mux
`timescale 1ns/100ps
module pxo_port0_out_test;
  import pxo_pkg::*;
  logic       mclk_in = 1'b0;
  logic       lclk    = 1'b0;
  logic       rst_in  = 1'b1;
  logic [2:0] strap   = 3'h0;
  logic       iso     = 1'b0;
  logic [3:0] nib     = 4'h0;
  logic       vld     = 1'b0;
  logic [3:0] d, oe, wd;
  logic       v, voe, rsv, ckd, wv;
  logic [2:0] rc, code;
  int         n_fail      = 0;
  int         checks_done = 0;

  always #50 mclk_in = ~mclk_in;
  always #32 lclk = ~lclk;

  pxo_port0_out DUT
  (
    .mclk_in                   (mclk_in),
    .rst_in                    (rst_in),
    .port0_out_ref_clock_in    (lclk),
    .port0_role_strap_code_in  (strap),
    .vphy_isolate_bit_in       (iso),
    .sw_out_nibble_in          (nib),
    .sw_out_valid_in           (vld),
    .port0_out_data_nibble_out (d),
    .port0_out_data_oe_out     (oe),
    .port0_out_valid_out       (v),
    .port0_out_valid_oe_out    (voe),
    .port0_role_code_out       (rc),
    .port0_role_reserved_out   (rsv),
    .port0_ref_clock_drive_out (ckd)
  );

  pxo_far_end FE
  (
    .ref_clock_in   (lclk),
    .data_in        (d),
    .data_oe_in     (oe),
    .valid_in       (v),
    .valid_oe_in    (voe),
    .wire_data_out  (wd),
    .wire_valid_out (wv)
  );

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [3:0] e_oe(input logic [2:0] c, input logic i);
    if (c == PXO_CODE_RESERVED)
      return PXO_OE_NONE;
    if (c != 3'h0 && i)
      return PXO_OE_NONE;
    return c[2] ? 4'h3 : 4'hf;
  endfunction

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one beat in, pins checked one link cycle later
  task automatic send(input logic [2:0] c, input logic [3:0] n,
                      input logic dv);
    logic [3:0] m;
    logic [3:0] x;
    logic       ev;
    @(posedge lclk) #2;
    nib = n;
    vld = dv;
    @(posedge lclk) #2;
    m = e_oe(c, iso);
    x = c[2] ? {2'h0, n[1:0]} : n;
    ev = c != 3'h7 && !(iso && c != 3'h0);
    chk(oe, m);
    chk(d, c == PXO_CODE_RESERVED ? 4'h0 : x);
    chk(wd & m, x & m);
    chk({3'h0, v}, {3'h0, c != 3'h7 && dv});
    chk({3'h0, voe}, {3'h0, ev});
    chk({3'h0, wv & ev}, {3'h0, dv & c != 3'h7 & ev});
  endtask

  // -------------------------------------------------------------
  // main sequence: every strap code, then isolate
  // -------------------------------------------------------------
  initial
  begin
    for (int c = 0; c < 8; c++)
    begin
      @(posedge mclk_in) #2;
      code   = c[2:0];
      rst_in = 1'b1;
      iso    = 1'b0;
      strap  = code;
      repeat (12) @(posedge mclk_in);
      #2 rst_in = 1'b0;
      // strap moved after release must not change the role
      strap = ~code;
      repeat (8) @(posedge mclk_in);
      #2;
      chk({1'b0, rc}, {1'b0, code});
      chk({3'h0, rsv}, {3'h0, code == 3'h7});
      chk({3'h0, ckd}, {3'h0, code != 0 && code < 6});
      send(code, 4'ha, 1'b1);
      send(code, 4'h5, 1'b0);
      send(code, 4'hf, 1'b1);
      iso = 1'b1;
      repeat (4) @(posedge lclk);
      send(code, 4'h6, 1'b1);
      send(code, 4'h9, 1'b0);
      iso = 1'b0;
      $display("test code %0d done", code);
    end
    results();
  end

  // hang guard
  initial
  begin
    #3000000;
    n_fail++;
    results();
  end
endmodule
